// ### common/bars_consts.svh
// Constants for the byte ALU slice
`ifndef BARS_CONSTS_SVH
`define BARS_CONSTS_SVH
`define BARS_DATA_W 8
`define BARS_ADDR_W 7
`define BARS_BYTE_ZERO 8'h00
`define BARS_NIB_ZERO 4'h0
`define BARS_WDOG_CLEAR 8'h00
`define BARS_PRE_CLEAR 8'h00
`define BARS_DEST_ACC 1'b0
`define BARS_DEST_FILE 1'b1
`define BARS_ADDR_ZERO 7'h00
`define BARS_FLAG_CLR 1'b0
`define BARS_FLAG_N_IDLE 1'b1
`define BARS_MSB 7
`define BARS_LSB 0
`define BARS_ROT_LSB 1
`define BARS_NIB_MSB 3
`define BARS_NIB_HI_LSB 4
`define BARS_BORROW_BIT 8
`define BARS_HALF_BORROW_BIT 4
`endif

// ### common/bars_pkg.sv
// Types for the byte ALU slice
package bars_pkg;
  typedef enum logic [2:0] {
    BARS_OP_NONE,
    BARS_OP_ROTR,
    BARS_OP_SUBF,
    BARS_OP_SUBL,
    BARS_OP_SWAP,
    BARS_OP_XORL,
    BARS_OP_XORF,
    BARS_OP_SLEEP
  } bars_op_t;
  typedef enum logic {
    BARS_RUN,
    BARS_HALT
  } bars_state_t;
endpackage

// ### hw/bars_alu.sv
// Execution slice: rotate, subtract, swap, xor and sleep
`timescale 1ns/1ns
`include "bars_consts.svh"

// Operation
// - Rotate right shifts the file byte through carry, only carry changes.
// - Destination bit 0 writes the accumulator, 1 writes the file address.
// - File minus accumulator sets carry and half-carry on no borrow.
// - Literal minus accumulator goes to the accumulator, flags updated.
// - Nibble swap exchanges the halves of the file byte, no flag changes.
// - Xor with literal goes to the accumulator and updates only zero.
// - Xor with file goes to the chosen destination and updates only zero.
// - Sleep loads the watchdog counter with zero and clears its prescaler.
// - Sleep clears power-down, sets time-out and halts with clock stopped.
module bars_alu (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire bars_pkg::bars_op_t op,
  input wire logic dest_sel,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_data,
  input wire logic [7:0] literal,
  input wire logic wake,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic power_down_flag_n,
  output logic time_out_flag_n,
  output logic [7:0] watchdog_counter,
  output logic [7:0] watchdog_prescaler,
  output logic file_we,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic halted,
  output logic osc_run
);
  // ==========================================================
  // State
  logic [7:0] acc_q, acc_d;
  logic c_q, c_d, hc_q, hc_d, z_q, z_d;
  logic pwr_n_q, pwr_n_d, tmo_n_q, tmo_n_d;
  logic [7:0] wdog_q, wdog_d, pre_q, pre_d;
  logic halt_q, halt_d, osc_q, osc_d;
  logic we_q, we_d;
  logic [6:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  bars_pkg::bars_state_t st_q, st_d;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BARS_BYTE_ZERO);
  endfunction

  // ==========================================================
  // Next-state datapath
  always_comb
  begin
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic [7:0] res;
    logic to_dest;
    diff = 9'h000;
    ndiff = 5'h00;
    res = `BARS_BYTE_ZERO;
    to_dest = 1'b0;
    acc_d = acc_q;
    c_d = c_q;
    hc_d = hc_q;
    z_d = z_q;
    pwr_n_d = pwr_n_q;
    tmo_n_d = tmo_n_q;
    wdog_d = wdog_q;
    pre_d = pre_q;
    we_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    st_d = st_q;
    if (st_q == bars_pkg::BARS_HALT)
    begin
      if (wake)
      begin
        st_d = bars_pkg::BARS_RUN;
      end
    end
    else if (op_valid)
    begin
      case (op)
        bars_pkg::BARS_OP_ROTR:
        begin
          res = {c_q, file_data[`BARS_MSB:`BARS_ROT_LSB]};
          c_d = file_data[`BARS_LSB];
          to_dest = 1'b1;
        end
        bars_pkg::BARS_OP_SUBF:
        begin
          diff = {1'b0, file_data} - {1'b0, acc_q};
          ndiff = {1'b0, file_data[`BARS_NIB_MSB:`BARS_LSB]}
            - {1'b0, acc_q[`BARS_NIB_MSB:`BARS_LSB]};
          res = diff[`BARS_MSB:`BARS_LSB];
          c_d = ~diff[`BARS_BORROW_BIT];
          hc_d = ~ndiff[`BARS_HALF_BORROW_BIT];
          z_d = is_zero(diff[`BARS_MSB:`BARS_LSB]);
          to_dest = 1'b1;
        end
        bars_pkg::BARS_OP_SUBL:
        begin
          diff = {1'b0, literal} - {1'b0, acc_q};
          ndiff = {1'b0, literal[`BARS_NIB_MSB:`BARS_LSB]}
            - {1'b0, acc_q[`BARS_NIB_MSB:`BARS_LSB]};
          acc_d = diff[`BARS_MSB:`BARS_LSB];
          c_d = ~diff[`BARS_BORROW_BIT];
          hc_d = ~ndiff[`BARS_HALF_BORROW_BIT];
          z_d = is_zero(diff[`BARS_MSB:`BARS_LSB]);
        end
        bars_pkg::BARS_OP_SWAP:
        begin
          res = {file_data[`BARS_NIB_MSB:`BARS_LSB],
            file_data[`BARS_MSB:`BARS_NIB_HI_LSB]};
          to_dest = 1'b1;
        end
        bars_pkg::BARS_OP_XORL:
        begin
          acc_d = acc_q ^ literal;
          z_d = is_zero(acc_q ^ literal);
        end
        bars_pkg::BARS_OP_XORF:
        begin
          res = acc_q ^ file_data;
          z_d = is_zero(res);
          to_dest = 1'b1;
        end
        bars_pkg::BARS_OP_SLEEP:
        begin
          wdog_d = `BARS_WDOG_CLEAR;
          pre_d = `BARS_PRE_CLEAR;
          pwr_n_d = `BARS_FLAG_CLR;
          tmo_n_d = `BARS_FLAG_N_IDLE;
          st_d = bars_pkg::BARS_HALT;
        end
        default:
        begin
          st_d = st_q;
        end
      endcase
      if (to_dest)
      begin
        if (dest_sel == `BARS_DEST_FILE)
        begin
          we_d = 1'b1;
          wa_d = file_addr;
          wd_d = res;
        end
        else
        begin
          acc_d = res;
        end
      end
    end
    halt_d = (st_d == bars_pkg::BARS_HALT);
    osc_d = (st_d == bars_pkg::BARS_RUN);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q <= `BARS_BYTE_ZERO;
      c_q <= `BARS_FLAG_CLR;
      hc_q <= `BARS_FLAG_CLR;
      z_q <= `BARS_FLAG_CLR;
      pwr_n_q <= `BARS_FLAG_N_IDLE;
      tmo_n_q <= `BARS_FLAG_N_IDLE;
      wdog_q <= `BARS_WDOG_CLEAR;
      pre_q <= `BARS_PRE_CLEAR;
      we_q <= `BARS_FLAG_CLR;
      wa_q <= `BARS_ADDR_ZERO;
      wd_q <= `BARS_BYTE_ZERO;
      st_q <= bars_pkg::BARS_RUN;
      halt_q <= `BARS_FLAG_CLR;
      osc_q <= `BARS_FLAG_N_IDLE;
    end
    else
    begin
      acc_q <= acc_d;
      c_q <= c_d;
      hc_q <= hc_d;
      z_q <= z_d;
      pwr_n_q <= pwr_n_d;
      tmo_n_q <= tmo_n_d;
      wdog_q <= wdog_d;
      pre_q <= pre_d;
      we_q <= we_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      st_q <= st_d;
      halt_q <= halt_d;
      osc_q <= osc_d;
    end
  end

  assign acc = acc_q;
  assign carry_flag = c_q;
  assign half_carry_flag = hc_q;
  assign zero_flag = z_q;
  assign power_down_flag_n = pwr_n_q;
  assign time_out_flag_n = tmo_n_q;
  assign watchdog_counter = wdog_q;
  assign watchdog_prescaler = pre_q;
  assign file_we = we_q;
  assign file_wr_addr = wa_q;
  assign file_wr_data = wd_q;
  assign halted = halt_q;
  assign osc_run = osc_q;

  // ==========================================================
  // Checks
  logic run_ok;
  assign run_ok = op_valid && (st_q == bars_pkg::BARS_RUN);

  AST_ROTATE: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_ROTR |=>
      carry_flag == $past(file_data[0])
      && zero_flag == $past(zero_flag)
      && half_carry_flag == $past(half_carry_flag))
    else $error("rotate flags wrong");
  AST_DEST_FILE: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SWAP && dest_sel |=> file_we
      && file_wr_addr == $past(file_addr) && acc == $past(acc))
    else $error("file destination wrong");
  AST_SUBF: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SUBF |=>
      carry_flag == ($past(acc) <= $past(file_data))
      && half_carry_flag == ($past(acc[3:0]) <= $past(file_data[3:0])))
    else $error("subtract file flags wrong");
  AST_SUBL: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SUBL |=>
      acc == 8'($past(literal) - $past(acc))
      && carry_flag == ($past(acc) <= $past(literal)))
    else $error("subtract literal wrong");
  AST_SWAP: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SWAP && !dest_sel |=>
      acc == {$past(file_data[3:0]), $past(file_data[7:4])}
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("swap wrong");
  AST_XORL: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_XORL |=>
      acc == ($past(acc) ^ $past(literal)) && $stable(carry_flag))
    else $error("xor literal wrong");
  AST_XORF: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_XORF && dest_sel |=>
      file_wr_data == ($past(acc) ^ $past(file_data)) && $stable(acc))
    else $error("xor file wrong");
  AST_SLEEP_WDT: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SLEEP |=>
      watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
    else $error("watchdog not cleared");
  AST_SLEEP_FLAGS: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SLEEP |=>
      !power_down_flag_n && time_out_flag_n && halted && !osc_run)
    else $error("sleep flags wrong");
  AST_ZERO: assert property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_XORL |=> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");

  COV_SLEEP: cover property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SLEEP ##1 halted ##[1:20] !halted);
  COV_BORROW: cover property (@(posedge clk) disable iff (rst)
    run_ok && op == bars_pkg::BARS_OP_SUBF ##1 !carry_flag);
  COV_FILE_WR: cover property (@(posedge clk) disable iff (rst)
    file_we);
endmodule

// ### tb/bars_alu_bench.sv
// Self-checking bench for the byte ALU slice
`timescale 1ns/1ns

module bars_alu_bench;
  logic clk, rst, op_valid, dest_sel, wake;
  bars_pkg::bars_op_t op;
  logic [6:0] file_addr, file_wr_addr;
  logic [7:0] file_data, literal, acc, file_wr_data, wdog, pre;
  logic carry_flag, half_carry_flag, zero_flag, power_down_flag_n;
  logic time_out_flag_n, file_we, halted, osc_run;
  logic [7:0] ea;
  logic ec, edc, ez;
  int fail_count, checks_done;

  bars_alu DUT (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op),
    .dest_sel(dest_sel), .file_addr(file_addr), .file_data(file_data),
    .literal(literal), .wake(wake), .acc(acc), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .power_down_flag_n(power_down_flag_n),
    .time_out_flag_n(time_out_flag_n), .watchdog_counter(wdog),
    .watchdog_prescaler(pre), .file_we(file_we),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .halted(halted), .osc_run(osc_run));

  // ==========================================
  // Clock and checking helpers
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // One operation with reference model
  task automatic run(input bars_pkg::bars_op_t o, input logic d,
    input logic [6:0] a, input logic [7:0] fd, input logic [7:0] k);
    logic [7:0] r, src;
    logic tf;
    case (o)
      bars_pkg::BARS_OP_ROTR: r = {ec, fd[7:1]};
      bars_pkg::BARS_OP_SUBF: r = fd - ea;
      bars_pkg::BARS_OP_SUBL: r = k - ea;
      bars_pkg::BARS_OP_SWAP: r = {fd[3:0], fd[7:4]};
      bars_pkg::BARS_OP_XORL: r = ea ^ k;
      default: r = ea ^ fd;
    endcase
    src = (o == bars_pkg::BARS_OP_SUBL) ? k : fd;
    if (o == bars_pkg::BARS_OP_ROTR) ec = fd[0];
    if (o inside {bars_pkg::BARS_OP_SUBF, bars_pkg::BARS_OP_SUBL})
    begin
      ec = ea <= src;
      edc = ea[3:0] <= src[3:0];
    end
    if (o inside {bars_pkg::BARS_OP_SUBF, bars_pkg::BARS_OP_SUBL,
      bars_pkg::BARS_OP_XORL, bars_pkg::BARS_OP_XORF}) ez = r == 8'h00;
    tf = d && o inside {bars_pkg::BARS_OP_ROTR, bars_pkg::BARS_OP_SUBF,
      bars_pkg::BARS_OP_SWAP, bars_pkg::BARS_OP_XORF};
    if (!tf && o != bars_pkg::BARS_OP_SLEEP) ea = r;
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    dest_sel <= d;
    file_addr <= a;
    file_data <= fd;
    literal <= k;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    chk("acc", acc, ea);
    chk("flags", {5'h00, carry_flag, half_carry_flag, zero_flag},
      {5'h00, ec, edc, ez});
    chk("we", {7'h00, file_we}, {7'h00, tf});
    if (tf) chk("wdata", file_wr_data, r);
    if (tf) chk("waddr", {1'b0, file_wr_addr}, {1'b0, a});
    @(posedge clk);
    #1;
    chk("we_end", {7'h00, file_we}, 8'h00);
  endtask

  // ==========================================
  // Scenarios
  task automatic s_xor();
    run(bars_pkg::BARS_OP_XORL, 1'b1, 7'h00, 8'hff, 8'h00);
    run(bars_pkg::BARS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h5a);
    run(bars_pkg::BARS_OP_XORF, 1'b1, 7'h7f, 8'h5a, 8'h00);
    run(bars_pkg::BARS_OP_XORF, 1'b0, 7'h00, 8'h0f, 8'h00);
  endtask

  task automatic s_sub();
    run(bars_pkg::BARS_OP_SUBF, 1'b1, 7'h7f, 8'h55, 8'h00);
    run(bars_pkg::BARS_OP_SUBF, 1'b1, 7'h01, 8'h54, 8'h00);
    run(bars_pkg::BARS_OP_SUBF, 1'b0, 7'h02, 8'h64, 8'h00);
    run(bars_pkg::BARS_OP_SUBL, 1'b1, 7'h00, 8'h00, 8'h0e);
    run(bars_pkg::BARS_OP_SUBL, 1'b0, 7'h00, 8'h00, 8'hff);
    run(bars_pkg::BARS_OP_SUBL, 1'b0, 7'h00, 8'h00, 8'h00);
  endtask

  task automatic s_rot_swap();
    run(bars_pkg::BARS_OP_ROTR, 1'b1, 7'h10, 8'h01, 8'h00);
    run(bars_pkg::BARS_OP_ROTR, 1'b0, 7'h10, 8'h80, 8'h00);
    run(bars_pkg::BARS_OP_ROTR, 1'b1, 7'h7f, 8'h02, 8'h00);
    run(bars_pkg::BARS_OP_SWAP, 1'b1, 7'h20, 8'ha5, 8'h00);
    run(bars_pkg::BARS_OP_SWAP, 1'b0, 7'h20, 8'h3c, 8'h00);
  endtask

  task automatic s_sleep();
    run(bars_pkg::BARS_OP_SLEEP, 1'b0, 7'h00, 8'hff, 8'h11);
    chk("wdog", wdog, 8'h00);
    chk("pre", pre, 8'h00);
    chk("sleep_flags", {6'h00, power_down_flag_n, time_out_flag_n},
      8'h01);
    chk("halt", {6'h00, halted, osc_run}, 8'h02);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= bars_pkg::BARS_OP_XORL;
    literal <= 8'hff;
    @(posedge clk);
    op_valid <= 1'b0;
    wake <= 1'b1;
    #1;
    chk("acc_halt", acc, ea);
    @(posedge clk);
    wake <= 1'b0;
    #1;
    chk("woken", {6'h00, halted, osc_run}, 8'h01);
    run(bars_pkg::BARS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h3c);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    {rst, op_valid, dest_sel, wake} = 4'h8;
    op = bars_pkg::BARS_OP_NONE;
    {file_addr, file_data, literal} = 23'h000000;
    {ea, ec, edc, ez} = 11'h000;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("flags_rst", {6'h00, power_down_flag_n, time_out_flag_n},
      8'h03);
    s_xor();
    s_sub();
    s_rot_swap();
    s_sleep();
    stop_test();
  end

  initial
  begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule
